// ===== gcb_base_setup.sv
`timescale 1ns/100ps
`default_nettype none

module gcb_base_setup (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  // write to the setup location, upper two byte lanes of the dword
  input  wire logic        wr_in,
  input  wire logic [1:0]  lane_en_in,
  input  wire logic [15:0] wdata_in,
  // programmed base and its valid flag
  output logic      [15:0] base_out,
  output logic             base_valid_out
);

  // one-shot capture; only reset re-arms it, so a stray later write cannot move the bank
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      base_out       <= 16'h0000;
      base_valid_out <= 1'b0;
    end else if (wr_in && !base_valid_out) begin  // R5
      if (lane_en_in[0]) begin
        base_out[7:0] <= wdata_in[7:0];
      end
      if (lane_en_in[1]) begin
        base_out[15:8] <= wdata_in[15:8];
      end
      base_valid_out <= 1'b1;  // R5
    end
  end

endmodule // gcb_base_setup

`default_nettype wire

// ===== gcb_bus_master.sv
`timescale 1ns/100ps
`default_nettype none
module gcb_bus_master (
  // clock
  input  wire logic        clk_in,
  // request
  output logic             req_out,
  output logic      [3:0]  cmd_out,
  output logic      [31:0] addr_out,
  output logic      [3:0]  be_n_out,
  output logic      [31:0] wdata_out,
  // answer
  input  wire logic        claim_in,
  input  wire logic [31:0] rdata_in
);
  // idle bus at time zero
  initial begin
    req_out = 1'b0;
    cmd_out = 4'h0;
    addr_out = 32'h0;
    be_n_out = 4'hf;
    wdata_out = 32'h0;
  end
  // one-cycle request, answer looked at in the claim cycle
  task automatic xfer(input logic [3:0] c, input logic [31:0] a, input logic [3:0] b,
                      input logic [31:0] d, output logic cl, output logic [31:0] rd);
    @(posedge clk_in);
    req_out <= 1'b1;
    cmd_out <= c;
    addr_out <= a;
    be_n_out <= b;
    wdata_out <= d;
    @(posedge clk_in);
    // released lines flip, so a stale copy is never mistaken for data
    req_out <= 1'b0;
    cmd_out <= ~c;
    addr_out <= ~a;
    be_n_out <= ~b;
    wdata_out <= ~d;
    @(negedge clk_in);
    cl = claim_in;
    rd = rdata_in;
  endtask
endmodule // gcb_bus_master
`default_nettype wire

// ===== gcb_checker.sv
`timescale 1ns/100ps
`default_nettype none
module gcb_checker (
  // clock and reset
  input wire logic        MCLK_IN,
  input wire logic        ARST_N_IN,
  // bus target side
  input wire logic        IO_REQ_IN,
  input wire logic [3:0]  IO_CMD_IN,
  input wire logic [31:0] IO_ADDR_IN,
  input wire logic [3:0]  IO_BE_N_IN,
  input wire logic        IO_CLAIM_OUT,
  input wire logic [31:0] IO_RDATA_OUT,
  // straps, events, state
  input wire logic [15:0] STRAP_CORE_FREQ_IN,
  input wire logic        WDOG_EVENT_IN,
  input wire logic        PIN_EVENT_IN,
  input wire logic        CLKGEN_EVENT_IN,
  input wire logic [15:0] CORE_FREQ_OUT,
  input wire logic [31:0] PIN_ROUTING_OUT,
  input wire logic [31:0] MISC_SETTINGS_OUT,
  input wire logic        IRQ_OUT,
  input wire logic        BASE_VALID_OUT,
  input wire logic        STRAPS_READY_OUT
);
  // single domain, so one clock and one reset for all
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!ARST_N_IN);
  property p_cmd;
    IO_REQ_IN && IO_CMD_IN != 4'h2 && IO_CMD_IN != 4'h3 |=> !IO_CLAIM_OUT;
  endproperty
  a_cmd: assert property (p_cmd)
    else $error("claim on a non-io command");
  property p_high;
    IO_REQ_IN && IO_ADDR_IN[31:16] != 16'h0 |=> !IO_CLAIM_OUT;
  endproperty
  a_high: assert property (p_high)
    else $error("claim above the 16-bit io space");
  // only the setup dword may answer before the base is known
  property p_pre;
    !BASE_VALID_OUT && IO_REQ_IN && IO_ADDR_IN[15:2] != 14'h00ba |=> !IO_CLAIM_OUT;
  endproperty
  a_pre: assert property (p_pre)
    else $error("claim before base programmed");
  property p_setup;
    !BASE_VALID_OUT && IO_REQ_IN && IO_CMD_IN == 4'h3 && IO_ADDR_IN[31:2] == 30'h0ba
      && IO_BE_N_IN[3:2] != 2'b11 |=> IO_CLAIM_OUT && BASE_VALID_OUT;
  endproperty
  a_setup: assert property (p_setup)
    else $error("setup write not taken");
  property p_lock;
    BASE_VALID_OUT |=> BASE_VALID_OUT;
  endproperty
  a_lock: assert property (p_lock)
    else $error("base lock dropped without reset");
  property p_rdz;
    !IO_CLAIM_OUT |-> IO_RDATA_OUT == 32'h0;
  endproperty
  a_rdz: assert property (p_rdz)
    else $error("read data outside a claim cycle");
  property p_rst;
    $rose(ARST_N_IN) |-> PIN_ROUTING_OUT == 32'h0 && MISC_SETTINGS_OUT == 32'h1;
  endproperty
  a_rst: assert property (p_rst)
    else $error("wrong reset value of routing or misc word");
  property p_freq;
    $rose(STRAPS_READY_OUT) |-> CORE_FREQ_OUT == STRAP_CORE_FREQ_IN;
  endproperty
  a_freq: assert property (p_freq)
    else $error("core frequency not loaded from strap");
  property p_lvl_irq;
    PIN_EVENT_IN || CLKGEN_EVENT_IN |=> IRQ_OUT;
  endproperty
  a_lvl_irq: assert property (p_lvl_irq)
    else $error("level event missing on interrupt");
  property p_wd_irq;
    WDOG_EVENT_IN |-> ##2 IRQ_OUT;
  endproperty
  a_wd_irq: assert property (p_wd_irq)
    else $error("watchdog event missing on interrupt");
  // main scenarios reached
  c_setup: cover property (!BASE_VALID_OUT ##1 BASE_VALID_OUT);
  c_read: cover property (IO_CLAIM_OUT && IO_RDATA_OUT != 32'h0);
  c_irq: cover property ($rose(IRQ_OUT));
endmodule // gcb_checker
bind gcb_config_bank gcb_checker gcb_checker_inst (.*);
`default_nettype wire

// ===== gcb_config_bank.sv
// Functional notes
// R1: bank is 64-byte I/O window at base
// R2: configuration cycles never select these registers
// R3: setup register answers at 02EAh until written
// R4: firmware programs base before other bus accesses
// R5: later setup writes ignored until system reset
// R6: reserved bits read back as last written
// R7: all functions share one routable interrupt output
// R8: offset 10h reads strapped maximum core multiplier
// R9: core frequency register resets from strap inputs
// R10: pin routing word resets to all zero
// R11: misc settings word resets with bit0 set
// R12: offsets 3Eh-3Fh read the bank base
// R13: claim only base..base+63; reserved offsets inert
`timescale 1ns/100ps
`default_nettype none

module gcb_config_bank
  import gcb_pkg::*;
#(
  parameter logic [7:0] CHIP_TYPE_VALUE = 8'h5a,  // arbitrary value
  parameter logic [7:0] STEP_VALUE      = 8'h01   // arbitrary value
) (
  // clock and reset
  input  wire logic        MCLK_IN,
  input  wire logic        ARST_N_IN,
  // internal bus target side
  input  wire logic        IO_REQ_IN,
  input  wire logic [3:0]  IO_CMD_IN,
  input  wire logic [31:0] IO_ADDR_IN,
  input  wire logic [3:0]  IO_BE_N_IN,
  input  wire logic [31:0] IO_WDATA_IN,
  output logic             IO_CLAIM_OUT,
  output logic      [31:0] IO_RDATA_OUT,
  // strap pins
  input  wire logic [7:0]  STRAP_MAX_MULT_IN,
  input  wire logic [15:0] STRAP_CORE_FREQ_IN,
  // function side inputs, same clock
  input  wire logic        WDOG_EVENT_IN,
  input  wire logic        TIMER_EVENT_IN,
  input  wire logic        PIN_EVENT_IN,
  input  wire logic        CLKGEN_EVENT_IN,
  input  wire logic [31:0] TIMER_COUNT_IN,
  // register contents toward the functions
  output logic      [15:0] WDOG_TIMEOUT_OUT,
  output logic      [15:0] WDOG_CONFIG_OUT,
  output logic      [7:0]  TIMER_SETUP_OUT,
  output logic      [7:0]  PLL_POWER_OUT,
  output logic      [31:0] PLL3_SETUP_OUT,
  output logic      [15:0] CORE_FREQ_OUT,
  output logic      [31:0] PIN_ROUTING_OUT,
  output logic      [31:0] MISC_SETTINGS_OUT,
  output logic      [7:0]  IRQ_ROUTE_OUT,
  // status
  output logic             IRQ_OUT,
  output logic             BASE_VALID_OUT,
  output logic             STRAPS_READY_OUT
);

  // programmed base of the bank
  logic [15:0] base;
  logic        base_valid;

  // strap handling
  logic [23:0] strap_sync;     // synchronised strap pins
  logic [1:0]  settle_cnt;     // cycles since reset release
  logic        strap_load;     // one-cycle load of strapped values
  logic [7:0]  max_mult;       // captured multiplier strap

  // bus decode
  logic        is_io_rd;       // io read command
  logic        is_io_wr;       // io write command
  logic        addr_hi_zero;   // address inside 16-bit io space
  logic        setup_hit;      // access to the setup location
  logic        bank_hit;       // access inside the bank window
  logic [3:0]  lane_en;        // active high byte lanes
  logic        next_claim;     // claim for the next cycle
  logic [31:0] next_rdata;     // read data for the next cycle

  // bank view, one byte per offset
  logic [7:0]  bank_byte [BANK_BYTES];
  logic [BANK_BYTES-1:0] wr_byte_en;  // byte written this cycle

  // strap pins come from outside the clock domain
  gcb_sync #(
    .WIDTH (24)
  ) u_strap_sync (
    .clk_in    (MCLK_IN),
    .arst_n_in (ARST_N_IN),
    .d_in      ({STRAP_CORE_FREQ_IN, STRAP_MAX_MULT_IN}),
    .q_out     (strap_sync)
  );

  // wait for the synchroniser to fill before trusting the straps
  always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      settle_cnt       <= 2'h0;
      STRAPS_READY_OUT <= 1'b0;
    end else if (!STRAPS_READY_OUT) begin
      settle_cnt <= settle_cnt + 2'h1;
      if (settle_cnt == STRAP_SETTLE_CYCLES - 2'h1) begin
        STRAPS_READY_OUT <= 1'b1;
      end
    end
  end

  // single load pulse, the last settle cycle
  assign strap_load = !STRAPS_READY_OUT && (settle_cnt == STRAP_SETTLE_CYCLES - 2'h1);

  // multiplier strap is caught once after release, never at the async reset
  always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      max_mult <= 8'h00;
    end else if (strap_load) begin
      max_mult <= strap_sync[7:0];  // R8
    end
  end

  // command and address decode; only io commands are ever looked at
  always_comb begin
    is_io_rd     = IO_CMD_IN == CMD_IO_READ;   // R2
    is_io_wr     = IO_CMD_IN == CMD_IO_WRITE;  // R2
    addr_hi_zero = IO_ADDR_IN[31:16] == 16'h0000;
    lane_en      = ~IO_BE_N_IN;
  end

  // setup location answers only while unprogrammed
  assign setup_hit = IO_REQ_IN && (is_io_rd || is_io_wr) && addr_hi_zero &&
                     (IO_ADDR_IN[15:2] == SETUP_IO_ADDR[15:2]) &&
                     (lane_en[3:2] != 2'b00) && !base_valid;  // R3

  // bank claims base..base+63 in io space only; base is taken as 64-byte aligned
  assign bank_hit = IO_REQ_IN && (is_io_rd || is_io_wr) && addr_hi_zero && base_valid &&
                    (IO_ADDR_IN[15:BANK_ADDR_BITS] == base[15:BANK_ADDR_BITS]);  // R1 R13

  // one-time base register
  gcb_base_setup u_base_setup (
    .clk_in         (MCLK_IN),
    .arst_n_in      (ARST_N_IN),
    .wr_in          (setup_hit && is_io_wr),  // R3
    .lane_en_in     (lane_en[3:2]),
    .wdata_in       (IO_WDATA_IN[31:16]),
    .base_out       (base),
    .base_valid_out (base_valid)
  );

  // per byte storage of the bank
  for (genvar i = 0; i < BANK_BYTES; i++) begin : g_byte
    localparam logic [5:0] OFS  = 6'(i);
    localparam int         LANE = i % 4;

    // byte selected by dword index and its byte lane
    assign wr_byte_en[i] = bank_hit && is_io_wr && (IO_ADDR_IN[5:2] == OFS[5:2]) && lane_en[LANE];

    if (gcb_byte_kind(OFS) == GCB_RW) begin : g_rw
      logic [7:0] q;       // stored byte, reserved bits included
      logic [7:0] next_q;  // value for the next edge

      // write, sticky flag and strap handling
      always_comb begin
        next_q = q;
        if (wr_byte_en[i]) begin
          next_q = IO_WDATA_IN[8*LANE +: 8];  // R6
        end
        if (OFS == OFS_WDOG_FLAGS) begin
          // write one to clear; a new event in the same cycle wins
          next_q = wr_byte_en[i] ? (q & ~IO_WDATA_IN[8*LANE +: 8]) : q;
          next_q[0] = next_q[0] | WDOG_EVENT_IN;  // R7
        end
        if (OFS == OFS_TIMER_FLAGS) begin
          // bit0 is sticky event, cleared by writing one; other bits plain storage
          next_q[0] = (q[0] & !(wr_byte_en[i] && IO_WDATA_IN[8*LANE])) | TIMER_EVENT_IN;  // R7
        end
        if ((OFS == OFS_CORE_FREQ || OFS == 6'h1f) && strap_load) begin
          // strap value replaces the reset value once the pins are settled
          // lane 2 takes the low strap byte, lane 3 the high one; index stays in range for every lane
          next_q = strap_sync[8 + 8*(LANE % 2) +: 8];  // R9
        end
      end

      // reset values from the package, pin routing all zero, misc bit0 set
      always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
          q <= gcb_byte_reset(OFS);  // R10 R11
        end else begin
          q <= next_q;
        end
      end

      assign bank_byte[i] = q;
    end else if (gcb_byte_kind(OFS) == GCB_RO) begin : g_ro
      // read-only bytes show timer count, strap, id and base values; writes are dropped
      if (OFS >= OFS_TIMER_COUNT && OFS <= 6'h0b) begin : g_count
        assign bank_byte[i] = TIMER_COUNT_IN[8*LANE +: 8];
      end else if (OFS == OFS_MAX_MULT) begin : g_mult
        assign bank_byte[i] = max_mult;  // R8
      end else if (OFS == OFS_CHIP_TYPE) begin : g_type
        assign bank_byte[i] = CHIP_TYPE_VALUE;
      end else if (OFS == OFS_STEP) begin : g_step
        assign bank_byte[i] = STEP_VALUE;
      end else begin : g_base
        assign bank_byte[i] = base[8*(LANE-2) +: 8];  // R12
      end
    end else begin : g_rsvd
      // unused offsets read zero and keep nothing
      assign bank_byte[i] = 8'h00;  // R13
    end
  end

  // read data and claim for the addressed dword
  always_comb begin
    next_claim = setup_hit || bank_hit;  // R13
    next_rdata = 32'h00000000;
    if (setup_hit && is_io_rd) begin
      // setup location reads back the (still empty) base
      next_rdata = {base, 16'h0000};
    end else if (bank_hit && is_io_rd) begin
      next_rdata = {bank_byte[{IO_ADDR_IN[5:2], 2'h3}],
                    bank_byte[{IO_ADDR_IN[5:2], 2'h2}],
                    bank_byte[{IO_ADDR_IN[5:2], 2'h1}],
                    bank_byte[{IO_ADDR_IN[5:2], 2'h0}]};
    end
  end

  // answer one cycle after the request
  always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      IO_CLAIM_OUT <= 1'b0;
      IO_RDATA_OUT <= 32'h00000000;
    end else begin
      IO_CLAIM_OUT <= next_claim;
      IO_RDATA_OUT <= next_rdata;
    end
  end

  // shared interrupt: any function raising its request drives the one line
  always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      IRQ_OUT <= 1'b0;
    end else begin
      IRQ_OUT <= bank_byte[OFS_WDOG_FLAGS][0] | bank_byte[OFS_TIMER_FLAGS][0] |
                 PIN_EVENT_IN | CLKGEN_EVENT_IN;  // R7
    end
  end

  // register contents toward the functions
  assign WDOG_TIMEOUT_OUT  = {bank_byte[OFS_WDOG_TIMEOUT + 6'h1], bank_byte[OFS_WDOG_TIMEOUT]};
  assign WDOG_CONFIG_OUT   = {bank_byte[OFS_WDOG_CONFIG + 6'h1], bank_byte[OFS_WDOG_CONFIG]};
  assign TIMER_SETUP_OUT   = bank_byte[OFS_TIMER_SETUP];
  assign PLL_POWER_OUT     = bank_byte[OFS_PLL_POWER];
  assign PLL3_SETUP_OUT    = {bank_byte[OFS_PLL3_SETUP + 6'h3], bank_byte[OFS_PLL3_SETUP + 6'h2],
                              bank_byte[OFS_PLL3_SETUP + 6'h1], bank_byte[OFS_PLL3_SETUP]};
  assign CORE_FREQ_OUT     = {bank_byte[OFS_CORE_FREQ + 6'h1], bank_byte[OFS_CORE_FREQ]};
  assign PIN_ROUTING_OUT   = {bank_byte[OFS_PIN_ROUTING + 6'h3], bank_byte[OFS_PIN_ROUTING + 6'h2],
                              bank_byte[OFS_PIN_ROUTING + 6'h1], bank_byte[OFS_PIN_ROUTING]};
  assign MISC_SETTINGS_OUT = {bank_byte[OFS_MISC + 6'h3], bank_byte[OFS_MISC + 6'h2],
                              bank_byte[OFS_MISC + 6'h1], bank_byte[OFS_MISC]};
  // routing select is handed to the interrupt router outside
  assign IRQ_ROUTE_OUT     = bank_byte[OFS_IRQ_ROUTE];  // R7
  assign BASE_VALID_OUT    = base_valid;

endmodule // gcb_config_bank

`default_nettype wire

// ===== gcb_pkg.sv
package gcb_pkg;

  // fixed location of the one-time base setup register after reset
  localparam logic [15:0] SETUP_IO_ADDR     = 16'h02ea;
  // bank size in bytes and the address bits that select a byte inside it
  localparam int          BANK_BYTES        = 64;
  localparam int          BANK_ADDR_BITS    = 6;

  // byte offsets of the registers inside the bank
  localparam logic [5:0]  OFS_WDOG_TIMEOUT  = 6'h00;
  localparam logic [5:0]  OFS_WDOG_CONFIG   = 6'h02;
  localparam logic [5:0]  OFS_WDOG_FLAGS    = 6'h04;
  localparam logic [5:0]  OFS_TIMER_COUNT   = 6'h08;
  localparam logic [5:0]  OFS_TIMER_FLAGS   = 6'h0c;
  localparam logic [5:0]  OFS_TIMER_SETUP   = 6'h0d;
  localparam logic [5:0]  OFS_MAX_MULT      = 6'h10;
  localparam logic [5:0]  OFS_PLL_POWER     = 6'h12;
  localparam logic [5:0]  OFS_PLL3_SETUP    = 6'h18;
  localparam logic [5:0]  OFS_CORE_FREQ     = 6'h1e;
  localparam logic [5:0]  OFS_PIN_ROUTING   = 6'h30;
  localparam logic [5:0]  OFS_MISC          = 6'h34;
  localparam logic [5:0]  OFS_IRQ_ROUTE     = 6'h38;
  localparam logic [5:0]  OFS_CHIP_TYPE     = 6'h3c;
  localparam logic [5:0]  OFS_STEP          = 6'h3d;
  localparam logic [5:0]  OFS_BASE_READBACK = 6'h3e;

  // values after reset of the writable registers
  localparam logic [15:0] RST_WDOG_TIMEOUT  = 16'h0000;
  localparam logic [15:0] RST_WDOG_CONFIG   = 16'h0000;
  localparam logic [7:0]  RST_WDOG_FLAGS    = 8'h00;
  localparam logic [7:0]  RST_TIMER_FLAGS   = 8'h00;
  localparam logic [7:0]  RST_TIMER_SETUP   = 8'h00;
  localparam logic [7:0]  RST_PLL_POWER     = 8'h2f;
  localparam logic [31:0] RST_PLL3_SETUP    = 32'he1040005;
  localparam logic [31:0] RST_PIN_ROUTING   = 32'h00000000;
  localparam logic [31:0] RST_MISC          = 32'h00000001;
  localparam logic [7:0]  RST_IRQ_ROUTE     = 8'h00;

  // bus command codes of the internal bus
  localparam logic [3:0]  CMD_IO_READ       = 4'h2;
  localparam logic [3:0]  CMD_IO_WRITE      = 4'h3;

  // cycles from reset release until the synchronised straps are trusted
  localparam logic [1:0]  STRAP_SETTLE_CYCLES = 2'h3;

  // what kind of storage sits behind each bank byte
  typedef enum {GCB_RSVD, GCB_RW, GCB_RO} gcb_kind_e;

  function automatic gcb_kind_e gcb_byte_kind(input logic [5:0] ofs);
    gcb_kind_e k;
    k = GCB_RSVD;
    if (ofs <= OFS_WDOG_FLAGS || ofs == OFS_TIMER_FLAGS || ofs == OFS_TIMER_SETUP ||
        ofs == OFS_PLL_POWER || (ofs >= OFS_PLL3_SETUP && ofs <= 6'h1b) ||
        ofs == OFS_CORE_FREQ || ofs == 6'h1f || (ofs >= OFS_PIN_ROUTING && ofs <= OFS_IRQ_ROUTE))
      k = GCB_RW;
    else if ((ofs >= OFS_TIMER_COUNT && ofs <= 6'h0b) || ofs == OFS_MAX_MULT || ofs >= OFS_CHIP_TYPE)
      k = GCB_RO;
    return k;
  endfunction

  function automatic logic [7:0] gcb_byte_reset(input logic [5:0] ofs);
    logic [7:0] v;
    v = 8'h00;
    if (ofs == OFS_PLL_POWER)
      v = RST_PLL_POWER;
    else if (ofs >= OFS_PLL3_SETUP && ofs <= 6'h1b)
      v = RST_PLL3_SETUP[8*ofs[1:0] +: 8];
    else if (ofs >= OFS_MISC && ofs <= 6'h37)
      v = RST_MISC[8*ofs[1:0] +: 8];
    return v;
  endfunction

endpackage

// ===== gcb_sync.sv
`timescale 1ns/100ps
`default_nettype none

module gcb_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             arst_n_in,
  // asynchronous level in, synchronised level out
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] meta;  // first stage, read only by the second

  // two flops; the first is never looked at by logic
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      meta  <= '0;
      q_out <= '0;
    end else begin
      meta  <= d_in;
      q_out <= meta;
    end
  end

endmodule // gcb_sync

`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import gcb_pkg::*;
  // design ports
  logic        MCLK_IN = 1'b0, ARST_N_IN = 1'b0, IO_REQ_IN, IO_CLAIM_OUT, IRQ_OUT, BASE_VALID_OUT;
  logic        STRAPS_READY_OUT, WDOG_EVENT_IN = 1'b0, TIMER_EVENT_IN = 1'b0;
  logic        PIN_EVENT_IN = 1'b0, CLKGEN_EVENT_IN = 1'b0;
  logic [3:0]  IO_CMD_IN, IO_BE_N_IN;
  logic [7:0]  STRAP_MAX_MULT_IN = 8'h0b, TIMER_SETUP_OUT, PLL_POWER_OUT, IRQ_ROUTE_OUT;
  logic [15:0] STRAP_CORE_FREQ_IN = 16'h1234, WDOG_TIMEOUT_OUT, WDOG_CONFIG_OUT, CORE_FREQ_OUT;
  logic [31:0] IO_ADDR_IN, IO_WDATA_IN, IO_RDATA_OUT, TIMER_COUNT_IN = 32'hc0de0123;
  logic [31:0] PLL3_SETUP_OUT, PIN_ROUTING_OUT, MISC_SETTINGS_OUT;
  int          fails = 0, checks = 0, cycles = 0;
  // dword offsets probed, values after reset and after writing all ones
  localparam logic [5:0]  ofs_tab [12] = '{6'h00, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h18, 6'h1c, 6'h20,
                                           6'h30, 6'h34, 6'h38, 6'h3c};
  localparam logic [31:0] rst_tab [12] = '{32'h0, 32'h0, 32'hc0de0123, 32'h0, 32'h002f000b, 32'he1040005,
                                           32'h12340000, 32'h0, 32'h0, 32'h1, 32'h0, 32'h4c40073c};
  localparam logic [31:0] set_tab [12] = '{32'hffffffff, 32'h0, 32'hc0de0123, 32'h0000fffe, 32'h00ff000b,
                                           32'hffffffff, 32'hffff0000, 32'h0, 32'hffffffff, 32'hffffffff,
                                           32'h000000ff, 32'h4c40073c};
  // id bytes are arbitrary values
  gcb_config_bank #(.CHIP_TYPE_VALUE(8'h3c), .STEP_VALUE(8'h07)) gcb_config_bank_inst (.*);
  gcb_bus_master gcb_bus_master_inst (.clk_in(MCLK_IN), .req_out(IO_REQ_IN), .cmd_out(IO_CMD_IN),
    .addr_out(IO_ADDR_IN), .be_n_out(IO_BE_N_IN), .wdata_out(IO_WDATA_IN), .claim_in(IO_CLAIM_OUT),
    .rdata_in(IO_RDATA_OUT));
  // 250 MHz clock
  always #2 MCLK_IN = ~MCLK_IN;
  task automatic tally_and_finish();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // hang guard, far above the fewer than 200 cycles the run needs
  always @(posedge MCLK_IN) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one access, claim and returned data both compared
  task automatic acc(input logic [3:0] c, input logic [31:0] a, input logic [3:0] b,
                     input logic [31:0] d, input logic ecl, input logic [31:0] erd);
    logic        cl;
    logic [31:0] rd;
    gcb_bus_master_inst.xfer(c, a, b, d, cl, rd);
    chk({31'h0, cl}, {31'h0, ecl});
    chk(rd, erd);
  endtask
  // bounded wait for the strap load after a reset release
  task automatic wait_ready();
    int n;
    n = 0;
    while (STRAPS_READY_OUT !== 1'b1 && n < 20) begin
      @(negedge MCLK_IN);
      n++;
    end
    chk({31'h0, STRAPS_READY_OUT}, 32'h1);
  endtask
  // main sequence
  initial begin
    repeat (20) @(posedge MCLK_IN);
    ARST_N_IN <= 1'b1;
    wait_ready();
    acc(CMD_IO_READ, 32'h4c70, 4'h0, 32'h0, 1'b0, 32'h0);
    acc(CMD_IO_READ, 32'h02e8, 4'h0, 32'h0, 1'b1, 32'h0);
    acc(CMD_IO_WRITE, 32'h02e8, 4'h3, 32'h4c400000, 1'b1, 32'h0);
    chk({31'h0, BASE_VALID_OUT}, 32'h1);
    acc(CMD_IO_WRITE, 32'h02e8, 4'h3, 32'h80000000, 1'b0, 32'h0);
    for (int i = 0; i < 12; i++) begin
      acc(CMD_IO_READ, 32'h4c40 + {26'h0, ofs_tab[i]}, 4'h0, 32'h0, 1'b1, rst_tab[i]);
    end
    // ones at every probed dword, read-only and reserved places included
    for (int i = 0; i < 12; i++) begin
      acc(CMD_IO_WRITE, 32'h4c40 + {26'h0, ofs_tab[i]}, 4'h0, 32'hffffffff, 1'b1, 32'h0);
    end
    for (int i = 0; i < 12; i++) begin
      acc(CMD_IO_READ, 32'h4c40 + {26'h0, ofs_tab[i]}, 4'h0, 32'h0, 1'b1, set_tab[i]);
    end
    chk(PIN_ROUTING_OUT, 32'hffffffff);
    // every register copy toward the functions follows the all-ones write
    chk({WDOG_CONFIG_OUT, WDOG_TIMEOUT_OUT}, 32'hffffffff);
    chk(PLL3_SETUP_OUT, 32'hffffffff);
    chk({IRQ_ROUTE_OUT, PLL_POWER_OUT, CORE_FREQ_OUT}, 32'hffffffff);
    chk({24'h0, TIMER_SETUP_OUT}, 32'h000000ff);
    chk(MISC_SETTINGS_OUT, 32'hffffffff);
    acc(CMD_IO_WRITE, 32'h4c70, 4'ha, 32'h11223344, 1'b1, 32'h0);
    // every command code: only io read and io write are claimed
    for (int c = 0; c < 16; c++) begin
      acc(4'(c), 32'h4c70, 4'h0, 32'(c), c == 2 || c == 3, (c == 2) ? 32'hff22ff44 : 32'h0);
    end
    acc(CMD_IO_READ, 32'h4c70, 4'h0, 32'h0, 1'b1, 32'h3);
    acc(CMD_IO_READ, 32'h4c80, 4'h0, 32'h0, 1'b0, 32'h0);
    acc(CMD_IO_READ, 32'h00014c70, 4'h0, 32'h0, 1'b0, 32'h0);
    acc(CMD_IO_READ, 32'h02e8, 4'h0, 32'h0, 1'b0, 32'h0);
    // watchdog and timer sticky flags raise and clear the interrupt
    @(posedge MCLK_IN) WDOG_EVENT_IN <= 1'b1;
    @(posedge MCLK_IN) WDOG_EVENT_IN <= 1'b0;
    acc(CMD_IO_READ, 32'h4c44, 4'h0, 32'h0, 1'b1, 32'h1);
    chk({31'h0, IRQ_OUT}, 32'h1);
    acc(CMD_IO_WRITE, 32'h4c44, 4'he, 32'h1, 1'b1, 32'h0);
    // registered interrupt drops one cycle after the clearing edge
    @(negedge MCLK_IN) chk({31'h0, IRQ_OUT}, 32'h0);
    @(posedge MCLK_IN) TIMER_EVENT_IN <= 1'b1;
    @(posedge MCLK_IN) TIMER_EVENT_IN <= 1'b0;
    acc(CMD_IO_READ, 32'h4c4c, 4'h0, 32'h0, 1'b1, 32'h0000ffff);
    chk({31'h0, IRQ_OUT}, 32'h1);
    acc(CMD_IO_WRITE, 32'h4c4c, 4'he, 32'h1, 1'b1, 32'h0);
    @(negedge MCLK_IN) chk({31'h0, IRQ_OUT}, 32'h0);
    // level sources, one after the other
    for (int i = 0; i < 2; i++) begin
      @(posedge MCLK_IN) {CLKGEN_EVENT_IN, PIN_EVENT_IN} <= 2'(1 << i);
      @(posedge MCLK_IN);
      @(negedge MCLK_IN) chk({31'h0, IRQ_OUT}, 32'h1);
    end
    @(posedge MCLK_IN) {CLKGEN_EVENT_IN, PIN_EVENT_IN} <= 2'b00;
    // second reset re-arms the setup location; single-lane base this time
    @(posedge MCLK_IN) ARST_N_IN <= 1'b0;
    repeat (3) @(posedge MCLK_IN);
    ARST_N_IN <= 1'b1;
    wait_ready();
    chk({31'h0, BASE_VALID_OUT}, 32'h0);
    chk(PIN_ROUTING_OUT, 32'h0);
    chk(MISC_SETTINGS_OUT, 32'h1);
    acc(CMD_IO_WRITE, 32'h02e8, 4'hb, 32'h00800000, 1'b1, 32'h0);
    acc(CMD_IO_READ, 32'h00bc, 4'h0, 32'h0, 1'b1, 32'h0080073c);
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
